// File: rtl/bec_consts.vh
/*
 Constants of the button event classifier: time figures, register
 offsets, field layout and reset values. Included by every design file.
*/
`ifndef BEC_CONSTS_VH
`define BEC_CONSTS_VH
// timebase
`define BEC_CLK_HZ       50000000
`define BEC_MS_PER_S     1000
// press classification limits in ms
`define BEC_TAP_MAX_MS   16'd500
`define BEC_SHORT_MAX_MS 16'd2000
`define BEC_LONG_MAX_MS  16'd5000
`define BEC_MS_MAX       16'hffff
// button event bits
`define BEC_BE_CHANGE    0
`define BEC_BE_HIGH      1
`define BEC_BE_LOW       2
`define BEC_BE_TAP       3
`define BEC_BE_SHORT     4
`define BEC_BE_LONG      5
`define BEC_BE_HOLD      6
`define BEC_BE_W         7
// sensor event bits
`define BEC_SE_CHANGE    0
`define BEC_SE_UPPER     1
`define BEC_SE_LOWER     2
`define BEC_SE_EXIT      3
`define BEC_SE_ENTER     4
`define BEC_SE_W         5
// register byte offsets
`define BEC_A_HOLD_DLY   8'h00
`define BEC_A_HOLD_PER   8'h04
`define BEC_A_STATUS     8'h08
`define BEC_A_BTN_EVT    8'h0c
`define BEC_A_SNS_EVT    8'h10
// slot region: bit 7 set, slot in bits 6:5, field in bits 4:2
`define BEC_F_VALUE      3'h0
`define BEC_F_LOW        3'h1
`define BEC_F_HIGH       3'h2
`define BEC_F_THR        3'h3
`define BEC_F_HYST       3'h4
// reset values
`define BEC_RST_DLY      16'h03e8
`define BEC_RST_PER      16'h01f4
`define BEC_RST_LOW      16'h8000
`define BEC_RST_HIGH     16'h7fff
`define BEC_RST_THR      16'h0000
`define BEC_RST_HYST     16'h0000
`endif

// File: rtl/bec_button.v
/*
 One dry-contact input: edge events, press duration classification and
 repeated hold events. Assumes a synchronised level and a 1 ms tick.
*/
`timescale 1ns/1ps
`include "bec_consts.vh"
module bec_button (
    input  wire        mclk,
    input  wire        resetn,
    input  wire        ce,
    input  wire        msTick,
    input  wire        level,
    input  wire [15:0] first_repeat_delay,
    input  wire [15:0] holdPeriod,
    output reg  [6:0]  evt
);
    reg        prev_q;
    reg        armed_q;
    reg [15:0] durMs_q;
    reg [15:0] holdMs_q;
    wire [15:0] holdNext = holdMs_q + 16'h0001;
    wire [15:0] holdGoal = armed_q ? holdPeriod : first_repeat_delay;

    // edge detection, duration and hold repeat timing
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            prev_q   <= 1'b0;
            armed_q  <= 1'b0;
            durMs_q  <= 16'h0000;
            holdMs_q <= 16'h0000;
            evt      <= 7'h00;
        end else if (ce) begin
            evt    <= 7'h00;
            prev_q <= level;
            if (level && !prev_q) begin
                evt[`BEC_BE_HIGH]   <= 1'b1;
                evt[`BEC_BE_CHANGE] <= 1'b1;
                durMs_q  <= 16'h0000;
                holdMs_q <= 16'h0000;
                armed_q  <= 1'b0;
            end else if (!level && prev_q) begin
                evt[`BEC_BE_LOW]    <= 1'b1;
                evt[`BEC_BE_CHANGE] <= 1'b1;
                evt[`BEC_BE_TAP]    <= durMs_q < `BEC_TAP_MAX_MS;
                evt[`BEC_BE_SHORT]  <= durMs_q >= `BEC_TAP_MAX_MS &&
                                       durMs_q < `BEC_SHORT_MAX_MS;
                evt[`BEC_BE_LONG]   <= durMs_q >= `BEC_SHORT_MAX_MS &&
                                       durMs_q <= `BEC_LONG_MAX_MS;
            end else if (level && msTick) begin
                if (durMs_q != `BEC_MS_MAX)
                    durMs_q <= durMs_q + 16'h0001;
                if (holdNext >= holdGoal) begin
                    evt[`BEC_BE_HOLD] <= 1'b1;
                    armed_q  <= 1'b1;
                    holdMs_q <= 16'h0000;
                end else begin
                    holdMs_q <= holdNext;
                end
            end
        end
    end
endmodule // bec_button

// File: rtl/bec_sensor.v
/*
 One temperature sensor slot: held reading, short-circuit forcing,
 hysteresis crossings and min/max window events. Assumes readings come
 from a sensor bus engine on the same clock.
*/
`timescale 1ns/1ps
`include "bec_consts.vh"
module bec_sensor (
    input  wire        mclk,
    input  wire        resetn,
    input  wire        ce,
    input  wire        update,
    input  wire [15:0] reading,
    input  wire        found,
    input  wire        busShort,
    input  wire [15:0] lowLim,
    input  wire [15:0] highLim,
    input  wire [15:0] thresh,
    input  wire [15:0] hyst,
    output reg  [15:0] value,
    output reg  [4:0]  evt
);
    reg  upState_q;
    reg  inWin_q;
    wire [15:0] nextVal = busShort ? 16'h0000 : reading;
    wire        take    = found & (update | busShort);
    wire signed [16:0] nv    = {nextVal[15], nextVal};
    wire signed [16:0] upper = {thresh[15], thresh} + {1'b0, hyst};
    wire signed [16:0] lower = {thresh[15], thresh} - {1'b0, hyst};
    wire signed [16:0] lo    = {lowLim[15], lowLim};
    wire signed [16:0] hi    = {highLim[15], highLim};
    wire win = (nv >= lo) && (nv <= hi);

    // reading update and event generation
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            value     <= 16'h0000;
            upState_q <= 1'b0;
            inWin_q   <= 1'b1;
            evt       <= 5'h00;
        end else if (ce) begin
            evt <= 5'h00;
            if (take) begin
                value <= nextVal;
                evt[`BEC_SE_CHANGE] <= nextVal != value;
                if (!upState_q && nv > upper) begin
                    upState_q <= 1'b1;
                    evt[`BEC_SE_UPPER] <= 1'b1;
                end
                if (upState_q && nv < lower) begin
                    upState_q <= 1'b0;
                    evt[`BEC_SE_LOWER] <= 1'b1;
                end
                inWin_q <= win;
                evt[`BEC_SE_EXIT]  <= inWin_q & ~win;
                evt[`BEC_SE_ENTER] <= ~inWin_q & win;
            end
        end
    end
endmodule // bec_sensor

// File: rtl/bec_top.v
/*
 Button and temperature event classifier with an AHB-Lite register slave.
 Assumes dry contacts arrive asynchronously on pins and sensor readings
 come from a sensor bus engine clocked by mclk.
*/
`timescale 1ns/1ps
`include "bec_consts.vh"
module bec_top #(
    parameter MS_CYCLES = `BEC_CLK_HZ / `BEC_MS_PER_S
) (
    input  wire        mclk,
    input  wire        resetn,
    input  wire        ce,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output wire        hreadyout,
    output wire        hresp,
    input  wire [1:0]  contactPin,
    input  wire        sensUpdate,
    input  wire [1:0]  sensSlot,
    input  wire [15:0] sensReading,
    input  wire [3:0]  sensFound,
    input  wire        sensShort,
    output reg         eventPending
);
    integer i;

    // pin synchronisers
    reg  [1:0]  sync1_q;
    reg  [1:0]  sync2_q;
    // millisecond timebase
    reg  [15:0] msCnt_q;
    reg         msTick_q;
    // settings
    reg  [15:0] holdDly_q;
    reg  [15:0] holdPer_q;
    reg  [15:0] lowLim_q  [0:3];
    reg  [15:0] highLim_q [0:3];
    reg  [15:0] thr_q     [0:3];
    reg  [15:0] hyst_q    [0:3];
    reg  [3:0]  found_q;
    reg         short_q;
    // events
    wire [13:0] btnEvt;
    wire [19:0] snsEvt;
    wire [63:0] values;
    reg  [13:0] btnSticky_q;
    reg  [19:0] snsSticky_q;
    // bus data phase
    reg         dpValid_q;
    reg         dpWrite_q;
    reg  [7:0]  dpAddr_q;

    wire        addrTake = hsel & hready & htrans[1] & ce;
    wire        wrEn     = dpValid_q & dpWrite_q & ce;
    wire        slotReg  = dpAddr_q[7];
    wire [1:0]  slot     = dpAddr_q[6:5];
    wire [2:0]  fld      = dpAddr_q[4:2];

    // wait while frozen, always okay
    assign hreadyout = ce;
    assign hresp     = 1'b0;

    // two-stage synchroniser for the contacts
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            sync1_q <= 2'b00;
            sync2_q <= 2'b00;
        end else if (ce) begin
            sync1_q <= contactPin;
            sync2_q <= sync1_q;
        end
    end

    // 1 ms tick divider
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            msCnt_q  <= 16'h0000;
            msTick_q <= 1'b0;
        end else if (ce) begin
            msTick_q <= 1'b0;
            if (msCnt_q == MS_CYCLES[15:0] - 16'h0001) begin
                msCnt_q  <= 16'h0000;
                msTick_q <= 1'b1;
            end else begin
                msCnt_q <= msCnt_q + 16'h0001;
            end
        end
    end

    // bus address phase capture
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            dpValid_q <= 1'b0;
            dpWrite_q <= 1'b0;
            dpAddr_q  <= 8'h00;
        end else if (ce) begin
            dpValid_q <= addrTake;
            if (addrTake) begin
                dpWrite_q <= hwrite;
                dpAddr_q  <= haddr[7:0];
            end
        end
    end

    // setting registers written by software
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            holdDly_q <= `BEC_RST_DLY;
            holdPer_q <= `BEC_RST_PER;
            for (i = 0; i < 4; i = i + 1) begin
                lowLim_q[i]  <= `BEC_RST_LOW;
                highLim_q[i] <= `BEC_RST_HIGH;
                thr_q[i]     <= `BEC_RST_THR;
                hyst_q[i]    <= `BEC_RST_HYST;
            end
        end else if (wrEn) begin
            if (dpAddr_q == `BEC_A_HOLD_DLY)
                holdDly_q <= hwdata[15:0];
            if (dpAddr_q == `BEC_A_HOLD_PER)
                holdPer_q <= hwdata[15:0];
            if (slotReg) begin
                case (fld)
                    `BEC_F_LOW:  lowLim_q[slot]  <= hwdata[15:0];
                    `BEC_F_HIGH: highLim_q[slot] <= hwdata[15:0];
                    `BEC_F_THR:  thr_q[slot]     <= hwdata[15:0];
                    `BEC_F_HYST: hyst_q[slot]    <= hwdata[15:0];
                    default: ;
                endcase
            end
        end
    end

    // discovered flags from the bus engine
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            found_q <= 4'h0;
            short_q <= 1'b0;
        end else if (ce) begin
            found_q <= sensFound;
            short_q <= sensShort;
        end
    end

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : gBtn
            bec_button uBtn (
                .mclk       (mclk),
                .resetn     (resetn),
                .ce         (ce),
                .msTick     (msTick_q),
                .level      (sync2_q[g]),
                .first_repeat_delay  (holdDly_q),
                .holdPeriod (holdPer_q),
                .evt        (btnEvt[g*`BEC_BE_W +: `BEC_BE_W])
            );
        end
        for (g = 0; g < 4; g = g + 1) begin : gSns
            bec_sensor uSns (
                .mclk     (mclk),
                .resetn   (resetn),
                .ce       (ce),
                .update   (sensUpdate && sensSlot == g),
                .reading  (sensReading),
                .found    (found_q[g]),
                .busShort (short_q),
                .lowLim   (lowLim_q[g]),
                .highLim  (highLim_q[g]),
                .thresh   (thr_q[g]),
                .hyst     (hyst_q[g]),
                .value    (values[g*16 +: 16]),
                .evt      (snsEvt[g*`BEC_SE_W +: `BEC_SE_W])
            );
        end
    endgenerate

    // sticky event flags, write one to clear, set wins
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            btnSticky_q  <= 14'h0000;
            snsSticky_q  <= 20'h00000;
            eventPending <= 1'b0;
        end else if (ce) begin
            btnSticky_q <= (btnSticky_q &
                ~((wrEn && dpAddr_q == `BEC_A_BTN_EVT) ? hwdata[13:0] : 14'h0000)) | btnEvt;
            snsSticky_q <= (snsSticky_q &
                ~((wrEn && dpAddr_q == `BEC_A_SNS_EVT) ? hwdata[19:0] : 20'h00000)) | snsEvt;
            eventPending <= (|btnSticky_q) | (|snsSticky_q);
        end
    end

    // read data mux for the data phase
    always @* begin
        hrdata = 32'h00000000;
        if (dpValid_q && !dpWrite_q) begin
            if (slotReg) begin
                case (fld)
                    `BEC_F_VALUE: hrdata = {16'h0000, values[slot*16 +: 16]};
                    `BEC_F_LOW:   hrdata = {16'h0000, lowLim_q[slot]};
                    `BEC_F_HIGH:  hrdata = {16'h0000, highLim_q[slot]};
                    `BEC_F_THR:   hrdata = {16'h0000, thr_q[slot]};
                    `BEC_F_HYST:  hrdata = {16'h0000, hyst_q[slot]};
                    default:      hrdata = 32'h00000000;
                endcase
            end else begin
                case (dpAddr_q)
                    `BEC_A_HOLD_DLY: hrdata = {16'h0000, holdDly_q};
                    `BEC_A_HOLD_PER: hrdata = {16'h0000, holdPer_q};
                    `BEC_A_STATUS:   hrdata = {23'h000000, short_q, found_q, 2'b00, sync2_q};
                    `BEC_A_BTN_EVT:  hrdata = {18'h00000, btnSticky_q};
                    `BEC_A_SNS_EVT:  hrdata = {12'h000, snsSticky_q};
                    default:         hrdata = 32'h00000000;
                endcase
            end
        end
    end
endmodule // bec_top

// File: verification/bec_sva.sv
/* port checker for bec_top: bus phases, timer settings, event flag.
   assumes hready is fed from hreadyout */
`timescale 1ns/1ps
`include "bec_consts.vh"
module bec_sva #(
    parameter MS_CYCLES = 50000
) (
    input wire        mclk,
    input wire        resetn,
    input wire        ce,
    input wire        hsel,
    input wire [31:0] haddr,
    input wire [1:0]  htrans,
    input wire        hwrite,
    input wire [31:0] hwdata,
    input wire        hready,
    input wire [31:0] hrdata,
    input wire        hreadyout,
    input wire        hresp,
    input wire [1:0]  contactPin,
    input wire        eventPending
);
    reg        rdPhase_q;
    reg        wrPhase_q;
    reg [7:0]  addr_q;
    reg [15:0] dly_q;
    reg [15:0] per_q;
    // shadow of the data phase and of the two timer settings
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rdPhase_q <= 1'b0;
            wrPhase_q <= 1'b0;
            addr_q    <= 8'h00;
            dly_q     <= `BEC_RST_DLY;
            per_q     <= `BEC_RST_PER;
        end else if (ce) begin
            if (wrPhase_q && addr_q == `BEC_A_HOLD_DLY)
                dly_q <= hwdata[15:0];
            if (wrPhase_q && addr_q == `BEC_A_HOLD_PER)
                per_q <= hwdata[15:0];
            rdPhase_q <= hsel & hready & htrans[1] & ~hwrite;
            wrPhase_q <= hsel & hready & htrans[1] & hwrite;
            addr_q    <= haddr[7:0];
        end
    end
    default clocking dc @(posedge mclk); endclocking
    default disable iff (!resetn);
    sequence s_rise; ce && $rose(contactPin[0]); endsequence
    sequence s_fall; ce && $fell(contactPin[1]); endsequence
    sequence s_pend; ##[1:5] eventPending; endsequence
    property p_okay; hresp == 1'b0; endproperty
    a_okay: assert property (p_okay) else $error("error response seen");
    property p_ready; hreadyout == ce; endproperty
    a_ready: assert property (p_ready) else $error("ready does not follow enable");
    property p_idle; !rdPhase_q |-> hrdata == 32'h0; endproperty
    a_idle: assert property (p_idle) else $error("read data outside read phase");
    property p_dly; rdPhase_q && addr_q == `BEC_A_HOLD_DLY |-> hrdata == {16'h0, dly_q}; endproperty
    a_dly: assert property (p_dly) else $error("hold delay readback wrong");
    property p_per; rdPhase_q && addr_q == `BEC_A_HOLD_PER |-> hrdata == {16'h0, per_q}; endproperty
    a_per: assert property (p_per) else $error("repeat period readback wrong");
    property p_unmap; rdPhase_q && addr_q > `BEC_A_SNS_EVT && addr_q < 8'h80 |-> hrdata == 32'h0; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_rise; s_rise |-> s_pend; endproperty
    a_rise: assert property (p_rise) else $error("no event after contact rise");
    property p_fall; s_fall |-> s_pend; endproperty
    a_fall: assert property (p_fall) else $error("no event after contact fall");
    property p_clear; $fell(eventPending) |-> $past(wrPhase_q) || $past(wrPhase_q, 2) || $past(wrPhase_q, 3);
    endproperty
    a_clear: assert property (p_clear) else $error("event flag dropped without a write");
endmodule // bec_sva

bind bec_top bec_sva #(.MS_CYCLES(MS_CYCLES)) bec_sva_inst (
    .mclk(mclk), .resetn(resetn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .contactPin(contactPin), .eventPending(eventPending)
);

// File: verification/bec_partner.sv
/* model of the push buttons and the sensor bus engine.
   assumes the bench calls its tasks from one process at a time per task */
`timescale 1ns/1ps
module bec_partner #(
    parameter MSC = 3
) (
    input  wire        mclk,
    output reg  [1:0]  contactPin,
    output reg         sensUpdate,
    output reg  [1:0]  sensSlot,
    output reg  [15:0] sensReading,
    output reg  [3:0]  sensFound,
    output reg         sensShort
);
    // idle levels
    initial begin
        contactPin  = 2'h0;
        sensUpdate  = 1'b0;
        sensSlot    = 2'h0;
        sensReading = 16'h0;
        sensFound   = 4'h0;
        sensShort   = 1'b0;
    end
    // hold one contact closed for a number of ms
    task automatic press(input int b, input int ms);
        @(posedge mclk);
        contactPin[b] <= 1'b1;
        repeat (ms * MSC) @(posedge mclk);
        contactPin[b] <= 1'b0;
    endtask
    // one reading pulse; released lines show the inverse afterwards
    task automatic sens(input logic [1:0] s, input logic [15:0] v);
        @(posedge mclk);
        sensUpdate  <= 1'b1;
        sensSlot    <= s;
        sensReading <= v;
        @(posedge mclk);
        sensUpdate  <= 1'b0;
        sensSlot    <= ~s;
        sensReading <= ~v;
    endtask
    // attached slots and bus short level
    task automatic lines(input logic [3:0] f, input logic sh);
        @(posedge mclk);
        sensFound <= f;
        sensShort <= sh;
    endtask
endmodule // bec_partner

// File: verification/bec_top_tb.sv
/* self-checking bench for bec_top: registers, press classes, sensors.
   assumes bec_partner drives the contacts and sensor lines */
`timescale 1ns/1ps
module bec_top_tb;
    localparam MSC = 3;
    reg          mclk;
    reg          resetn;
    reg          ce;
    reg          hsel;
    reg          hwrite;
    reg  [1:0]   htrans;
    reg  [31:0]  haddr;
    reg  [31:0]  hwdata;
    wire         hreadyout;
    wire         hresp;
    wire         eventPending;
    wire [31:0]  hrdata;
    wire [1:0]   contactPin;
    wire         sensUpdate;
    wire [1:0]   sensSlot;
    wire [15:0]  sensReading;
    wire [3:0]   sensFound;
    wire         sensShort;
    int          mismatches;
    int          nTests;
    int          i;
    logic [31:0] rd;
    int          durMs [6] = '{450, 550, 1950, 2050, 4950, 5100};
    logic [6:0]  cls [6] = '{7'h08, 7'h10, 7'h10, 7'h20, 7'h20, 7'h00};
    logic [15:0] rdg [5] = '{16'h0100, 16'h0500, 16'h0100, 16'h0300, 16'h0150};
    logic [4:0]  sEx [5] = '{5'h01, 5'h03, 5'h05, 5'h09, 5'h11};
    logic [4:0]  sMk [5] = '{5'h01, 5'h0b, 5'h07, 5'h19, 5'h19};
    bec_top #(.MS_CYCLES(MSC)) bec_top_inst (
        .mclk(mclk), .resetn(resetn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .contactPin(contactPin), .sensUpdate(sensUpdate),
        .sensSlot(sensSlot), .sensReading(sensReading), .sensFound(sensFound), .sensShort(sensShort),
        .eventPending(eventPending)
    );
    bec_partner #(.MSC(MSC)) bec_partner_inst (
        .mclk(mclk), .contactPin(contactPin), .sensUpdate(sensUpdate), .sensSlot(sensSlot),
        .sensReading(sensReading), .sensFound(sensFound), .sensShort(sensShort)
    );
    // 50 MHz clock
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    // single word transfer, read data left in rd
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge mclk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr  <= {24'h0, a};
        @(posedge mclk);
        while (hreadyout !== 1'b1) @(posedge mclk);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge mclk);
        while (hreadyout !== 1'b1) @(posedge mclk);
        rd = hrdata;
    endtask
    // masked compare
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
        nTests++;
        if ((got & m) !== (exp & m)) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
        bus(1'b0, a, 32'h0);
        chk(rd, exp, m);
    endtask
    task print_verdict;
        $display("comparisons %0d mismatches %0d", nTests, mismatches);
        if (mismatches == 0 && nTests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // hang guard, about 1.65 times the expected run
    initial begin
        #1500000;
        mismatches++;
        print_verdict;
    end
    // main sequence
    initial begin
        {resetn, ce, hsel, hwrite, htrans, haddr, hwdata} = {1'b0, 1'b1, 68'h0};
        {mismatches, nTests, rd} = 0;
        repeat (3) @(posedge mclk);
        resetn <= 1'b1;
        rc(8'h00, 32'h3e8, '1);
        rc(8'h04, 32'h1f4, '1);
        rc(8'h84, 32'h8000, '1);
        rc(8'ha8, 32'h7fff, '1);
        bus(1'b1, 8'h14, '1);
        rc(8'h14, 32'h0, '1);
        ce <= 1'b0;
        repeat (3) @(posedge mclk);
        ce <= 1'b1;
        bus(1'b1, 8'h00, 32'h6);
        bus(1'b1, 8'h04, 32'h2);
        rc(8'h00, 32'h6, '1);
        rc(8'h04, 32'h2, '1);
        // press length classes on alternating inputs
        for (i = 0; i < 6; i++) begin
            bus(1'b1, 8'h0c, 32'h3fff);
            bec_partner_inst.press(i % 2, durMs[i]);
            repeat (6) @(posedge mclk);
            rc(8'h0c, {25'h0, 7'h47 | cls[i]} << (7 * (i % 2)), '1);
            chk({31'h0, eventPending}, 32'h1, 32'h1);
        end
        // first hold after the delay, then repeats
        bus(1'b1, 8'h0c, 32'h3fff);
        fork
            bec_partner_inst.press(1, 20);
        join_none
        repeat (6) @(posedge mclk);
        rc(8'h0c, 32'h0180, 32'h2180);
        repeat (20) @(posedge mclk);
        bus(1'b1, 8'h0c, 32'h3fff);
        repeat (12) @(posedge mclk);
        rc(8'h0c, 32'h2000, 32'h2000);
        repeat (20) @(posedge mclk);
        rc(8'h0c, 32'h0600, 32'h0600);
        // slot 0: crossings and window, threshold and hysteresis set first
        bec_partner_inst.lines(4'h5, 1'b0);
        bus(1'b1, 8'h8c, 32'h0400);
        bus(1'b1, 8'h90, 32'h0010);
        for (i = 0; i < 5; i++) begin
            if (i == 3) bus(1'b1, 8'h88, 32'h0200);
            bus(1'b1, 8'h10, 32'hfffff);
            bec_partner_inst.sens(2'h0, rdg[i]);
            repeat (3) @(posedge mclk);
            rc(8'h10, {27'h0, sEx[i]}, {27'h0, sMk[i]});
            rc(8'h80, {16'h0, rdg[i]}, '1);
        end
        rc(8'h08, 32'h50, 32'h1f0);
        bus(1'b1, 8'h10, 32'hfffff);
        bec_partner_inst.sens(2'h1, 16'h0222);
        repeat (3) @(posedge mclk);
        rc(8'h10, 32'h0, 32'h3e0);
        // vanished sensor, then bus short
        bec_partner_inst.lines(4'h4, 1'b0);
        bec_partner_inst.sens(2'h0, 16'h0123);
        repeat (3) @(posedge mclk);
        rc(8'h80, 32'h0150, '1);
        bec_partner_inst.lines(4'h5, 1'b1);
        repeat (4) @(posedge mclk);
        rc(8'h80, 32'h0, '1);
        rc(8'h08, 32'h150, 32'h1f0);
        bec_partner_inst.lines(4'h5, 1'b0);
        bus(1'b1, 8'h0c, '1);
        bus(1'b1, 8'h10, '1);
        repeat (4) @(posedge mclk);
        chk({31'h0, eventPending}, 32'h0, 32'h1);
        print_verdict;
    end
endmodule // bec_top_tb
